/* core/cal_pkg.sv */
// constants and types shared by the calibration control block
package cal_pkg;

  localparam logic [7:0] ADDR_CTRL_ONE  = 8'h60;
  localparam logic [7:0] ADDR_CTRL_TWO  = 8'h61;
  localparam logic [7:0] ADDR_RING_RES  = 8'h62;
  localparam logic [7:0] ADDR_TIP_RES   = 8'h63;

  localparam int         BIT_SYS_CAL    = 6;
  localparam int         BIT_SPEEDUP    = 5;
  localparam int         STEP_FIELD_W   = 5;
  localparam int         NUM_STEPS      = 10;
  localparam int         RESULT_W       = 5;
  localparam int         TIMER_W        = 32;

  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h1F;
  localparam logic [4:0] RESULT_RESET   = 5'h10;

  localparam int         CLK_KHZ         = 125000;
  localparam int         SETTLE_LONG_MS  = 300;
  localparam int         SETTLE_SHORT_MS = 30;
  localparam int         SETTLE_LONG_CYC  = SETTLE_LONG_MS * CLK_KHZ;
  localparam int         SETTLE_SHORT_CYC = SETTLE_SHORT_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_STEP
  } cal_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       load_ring;
    logic       load_tip;
    logic [4:0] value;
  } cal_result_t;

endpackage : cal_pkg

/* core/cal_timer.sv */
// down counter that pulses once when a loaded wait runs out
`timescale 1ns/100ps
`default_nettype none
module cal_timer #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic         expired_r;
  logic         expired_nxt;

  always_comb begin
    count_nxt   = count_r;
    expired_nxt = 1'b0;
    if (load) begin
      count_nxt = load_val;
    end else if (count_r != '0) begin
      count_nxt = count_r - 1'b1;
      if (count_r == {{(W-1){1'b0}}, 1'b1}) begin
        expired_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r   <= '0;
      expired_r <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      expired_r <= expired_nxt;
    end
  end

  assign expired = expired_r;

endmodule : cal_timer
`default_nettype wire

/* core/calibration_control_status.sv */
// calibration control/status registers and step sequencer
//
// Overview of operation
// - writing one to bit 6 of the first control register launches a whole-device calibration.
// - bit 6 reads one while that calibration runs and zero when done or idle.
// - bit 5 picks the battery settle wait at the start: 300 ms when clear, 30 ms when set.
// - bit 4 of the first register enables the ring mismatch step and shows its status.
// - bit 3 of the first register enables the tip mismatch step and shows its status.
// - bit 2 of the first register enables the differential DAC gain step and shows its status.
// - bit 1 of the first register enables the common-mode DAC gain step and shows its status.
// - each step bit, current limit at bit 0 included, reads one while enabled or running and clears on completion.
// - bits 4 and 3 of the second register enable the two monitor ADC steps and report them.
// - setting bit 2 of the second register starts audio DAC offset calibration.
// - setting bit 1 of the second register starts audio ADC offset calibration.
// - setting bit 0 of the second register starts longitudinal balance calibration.
// - reserved upper bits of all these registers read zero.
// - the ring mismatch result is a 5-bit read/write field in the low bits of its register.
// - the tip mismatch result is a 5-bit read/write field in the low bits of the next register.
`timescale 1ns/100ps
`default_nettype none
module calibration_control_status
  import cal_pkg::*;
#(
  parameter int unsigned SETTLE_LONG_CYCLES  = SETTLE_LONG_CYC,
  parameter int unsigned SETTLE_SHORT_CYCLES = SETTLE_SHORT_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire reg_req_t             reg_req,
  output logic [7:0]                reg_rdata,
  output logic [NUM_STEPS-1:0]      step_req,
  input  wire logic                 step_done,
  input  wire cal_result_t          cal_result,
  output logic                      settle_active,
  output logic                      cal_busy
);

  cal_state_t                 state_r;
  cal_state_t                 state_nxt;
  logic                       sys_cal_r;
  logic                       sys_cal_nxt;
  logic                       speedup_r;
  logic                       speedup_nxt;
  logic [NUM_STEPS-1:0]       steps_r;
  logic [NUM_STEPS-1:0]       steps_nxt;
  logic [NUM_STEPS-1:0]       step_req_r;
  logic [NUM_STEPS-1:0]       step_req_nxt;
  logic [RESULT_W-1:0]        ring_res_r;
  logic [RESULT_W-1:0]        ring_res_nxt;
  logic [RESULT_W-1:0]        tip_res_r;
  logic [RESULT_W-1:0]        tip_res_nxt;
  logic [7:0]                 rdata_r;
  logic [7:0]                 rdata_nxt;
  logic                       timer_load;
  logic [TIMER_W-1:0]         timer_val;
  logic                       settle_done;
  logic [NUM_STEPS-1:0]       cur_step;
  logic                       wr_one;
  logic                       wr_two;

  // highest enabled step runs first: ring, tip, ... longitudinal balance
  function automatic logic [NUM_STEPS-1:0] top_step(input logic [NUM_STEPS-1:0] v);
    logic [NUM_STEPS-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_STEPS; i++) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : top_step

  cal_timer #(
    .W (TIMER_W)
  ) u_settle_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (timer_load),
    .load_val (timer_val),
    .expired  (settle_done)
  );

  assign cur_step = top_step(steps_r);
  assign wr_one   = reg_req.wr && (reg_req.addr == ADDR_CTRL_ONE);
  assign wr_two   = reg_req.wr && (reg_req.addr == ADDR_CTRL_TWO);

  // sequencer and control bits
  always_comb begin
    state_nxt    = state_r;
    sys_cal_nxt  = sys_cal_r;
    speedup_nxt  = speedup_r;
    steps_nxt    = steps_r;
    step_req_nxt = step_req_r;
    timer_load   = 1'b0;
    timer_val    = (speedup_r ? TIMER_W'(SETTLE_SHORT_CYCLES)
                              : TIMER_W'(SETTLE_LONG_CYCLES));
    case (state_r)
      ST_IDLE: begin
        if (wr_one) begin
          speedup_nxt              = reg_req.wdata[BIT_SPEEDUP];
          steps_nxt[NUM_STEPS-1:STEP_FIELD_W] = reg_req.wdata[STEP_FIELD_W-1:0];
          if (reg_req.wdata[BIT_SYS_CAL]) begin
            sys_cal_nxt = 1'b1;
            state_nxt   = ST_SETTLE;
            timer_load  = 1'b1;
            timer_val   = (reg_req.wdata[BIT_SPEEDUP] ? TIMER_W'(SETTLE_SHORT_CYCLES)
                                                      : TIMER_W'(SETTLE_LONG_CYCLES));
          end
        end else if (wr_two) begin
          steps_nxt[STEP_FIELD_W-1:0] = reg_req.wdata[STEP_FIELD_W-1:0];
          if (reg_req.wdata[2:0] != 3'h0) begin
            state_nxt = ST_STEP;
          end
        end
      end
      ST_SETTLE: begin
        if (settle_done) begin
          state_nxt = ST_STEP;
        end
      end
      ST_STEP: begin
        if (step_req_r == '0) begin
          if (steps_r == '0) begin
            state_nxt   = ST_IDLE;
            sys_cal_nxt = 1'b0;
          end else begin
            step_req_nxt = cur_step;
          end
        end else if (step_done) begin
          steps_nxt    = steps_r & ~step_req_r;
          step_req_nxt = '0;
        end
      end
      default: begin
        state_nxt    = ST_IDLE;
        sys_cal_nxt  = 1'b0;
        step_req_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      sys_cal_r  <= CTRL_ONE_RESET[BIT_SYS_CAL];
      speedup_r  <= CTRL_ONE_RESET[BIT_SPEEDUP];
      steps_r    <= {CTRL_ONE_RESET[STEP_FIELD_W-1:0], CTRL_TWO_RESET[STEP_FIELD_W-1:0]};
      step_req_r <= '0;
    end else begin
      state_r    <= state_nxt;
      sys_cal_r  <= sys_cal_nxt;
      speedup_r  <= speedup_nxt;
      steps_r    <= steps_nxt;
      step_req_r <= step_req_nxt;
    end
  end

  // result fields; a result load from the engine wins over a software write
  always_comb begin
    ring_res_nxt = ring_res_r;
    tip_res_nxt  = tip_res_r;
    if (reg_req.wr && (reg_req.addr == ADDR_RING_RES)) begin
      ring_res_nxt = reg_req.wdata[RESULT_W-1:0];
    end
    if (reg_req.wr && (reg_req.addr == ADDR_TIP_RES)) begin
      tip_res_nxt = reg_req.wdata[RESULT_W-1:0];
    end
    if (cal_result.load_ring) begin
      ring_res_nxt = cal_result.value;
    end
    if (cal_result.load_tip) begin
      tip_res_nxt = cal_result.value;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_res_r <= RESULT_RESET;
      tip_res_r  <= RESULT_RESET;
    end else begin
      ring_res_r <= ring_res_nxt;
      tip_res_r  <= tip_res_nxt;
    end
  end

  // read data, registered on the read strobe
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_CTRL_ONE: rdata_nxt = {1'b0, sys_cal_r, speedup_r,
                                    steps_r[NUM_STEPS-1:STEP_FIELD_W]};
        ADDR_CTRL_TWO: rdata_nxt = {3'h0, steps_r[STEP_FIELD_W-1:0]};
        ADDR_RING_RES: rdata_nxt = {3'h0, ring_res_r};
        ADDR_TIP_RES:  rdata_nxt = {3'h0, tip_res_r};
        default:       rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata     = rdata_r;
  assign step_req      = step_req_r;
  assign settle_active = (state_r == ST_SETTLE);
  assign cal_busy      = (state_r != ST_IDLE);

endmodule : calibration_control_status
`default_nettype wire

/* tb/calibration_control_status_chk.sv */
// assertions on the calibration register block ports
`timescale 1ns/100ps
`default_nettype none
module calibration_control_status_chk
  import cal_pkg::*;
#(
  parameter int unsigned SETTLE_LONG_CYCLES  = 40,
  parameter int unsigned SETTLE_SHORT_CYCLES = 8
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire reg_req_t             reg_req,
  input wire logic [7:0]           reg_rdata,
  input wire logic [NUM_STEPS-1:0] step_req,
  input wire logic                 step_done,
  input wire cal_result_t          cal_result,
  input wire logic                 settle_active,
  input wire logic                 cal_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_launch;
    reg_req.wr && reg_req.addr == ADDR_CTRL_ONE && reg_req.wdata[6] && !cal_busy;
  endsequence
  sequence s_step_end;
    step_req != 0 && step_done;
  endsequence
  chk_launch_settle: assert property (s_launch |=> cal_busy && settle_active)
    else $error("launch did not start settle");
  chk_idle_sys_bit: assert property (reg_req.rd && reg_req.addr == ADDR_CTRL_ONE && !cal_busy
    |=> !reg_rdata[6]) else $error("system bit set while idle");
  chk_settle_quiet: assert property (settle_active |-> cal_busy && step_req == 0)
    else $error("step raised during settle");
  chk_step_hold: assert property (step_req != 0 && !step_done |=> $stable(step_req))
    else $error("step request changed early");
  chk_step_drop: assert property (s_step_end |=> step_req == 0)
    else $error("step request not dropped");
  chk_next_step: assert property (s_step_end |-> ##[1:3] (step_req != 0 || !cal_busy))
    else $error("sequencer stalled after step");
  chk_one_step: assert property ($onehot0(step_req))
    else $error("more than one step requested");
  chk_bit7_zero: assert property (reg_req.rd |=> !reg_rdata[7])
    else $error("reserved bit 7 read one");
  chk_upper_zero: assert property (reg_req.rd && reg_req.addr inside {8'h61, 8'h62, 8'h63}
    |=> reg_rdata[7:5] == 3'h0) else $error("reserved bits read one");
endmodule : calibration_control_status_chk
`default_nettype wire

/* tb/calibration_control_status_test.sv */
// self-checking bench for the calibration register block
`timescale 1ns/100ps
`default_nettype none
module calibration_control_status_test
  import cal_pkg::*;
;
  localparam int L = 40;
  localparam int S = 8;
  logic        clk, rst_n, done, settle, busy;
  reg_req_t    rq;
  cal_result_t res;
  logic [7:0]  rdata;
  logic [9:0]  sreq;
  int          err_count, checks_done;
  time         t0, ts;

  calibration_control_status #(.SETTLE_LONG_CYCLES(L), .SETTLE_SHORT_CYCLES(S)) DUT (
    .clk(clk), .rst_n(rst_n), .reg_req(rq), .reg_rdata(rdata), .step_req(sreq),
    .step_done(done), .cal_result(res), .settle_active(settle), .cal_busy(busy));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic give_verdict;
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic cmp(input string n, input logic [9:0] e, input logic [9:0] s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) rq <= {1'b1, 1'b0, a, d};
    @(posedge clk) rq <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) rq <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk) rq <= '0;
    #1 cmp("rdata", {2'h0, e}, {2'h0, rdata});
  endtask : rd

  // waits for a step, checks it, answers with done, and with a result load for the ring and tip steps
  task automatic serve(input logic [9:0] e);
    int i;
    for (i = 0; i < 200 && sreq == 0; i++) begin
      @(posedge clk);
      #1;
    end
    ts = $time;
    cmp("step_req", e, sreq);
    if (i >= 200) give_verdict;
    @(posedge clk) res <= {e[9], e[8], 5'h0B};
    done <= 1'b1;
    @(posedge clk) res <= '0;
    done <= 1'b0;
    @(posedge clk);
    #1;
  endtask : serve

  task automatic idle;
    int i;
    for (i = 0; i < 50 && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    cmp("cal_busy", 10'h000, {9'h0, busy});
    if (i >= 50) give_verdict;
  endtask : idle

  initial begin
    rst_n = 1'b0;
    rq = '0;
    res = '0;
    done = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h60, 8'h00);
    rd(8'h61, 8'h1F);
    rd(8'h62, 8'h10);
    rd(8'h63, 8'h10);
    rd(8'h64, 8'h00);
    wr(8'h62, 8'hFF);
    rd(8'h62, 8'h1F);
    wr(8'h63, 8'hEA);
    rd(8'h63, 8'h0A);
    wr(8'h61, 8'h18);
    wr(8'h60, 8'hF4);
    t0 = $time;
    rd(8'h60, 8'h74);
    wr(8'h60, 8'h00);
    rd(8'h60, 8'h74);
    serve(10'h200);
    cmp("short settle", 10'h001, {9'h0, ((ts - t0) / 8) inside {[S + 1:S + 4]}});
    serve(10'h080);
    serve(10'h010);
    serve(10'h008);
    idle;
    rd(8'h60, 8'h20);
    rd(8'h61, 8'h00);
    rd(8'h62, 8'h0B);
    wr(8'h60, 8'h4B);
    t0 = $time;
    serve(10'h100);
    cmp("long settle", 10'h001, {9'h0, ((ts - t0) / 8) inside {[L + 1:L + 4]}});
    serve(10'h040);
    serve(10'h020);
    idle;
    rd(8'h60, 8'h00);
    rd(8'h63, 8'h0B);
    wr(8'h61, 8'h07);
    serve(10'h004);
    serve(10'h002);
    serve(10'h001);
    idle;
    rd(8'h61, 8'h00);
    give_verdict;
  end
endmodule : calibration_control_status_test

bind calibration_control_status calibration_control_status_chk #(
  .SETTLE_LONG_CYCLES(SETTLE_LONG_CYCLES), .SETTLE_SHORT_CYCLES(SETTLE_SHORT_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .step_req(step_req),
  .step_done(step_done), .cal_result(cal_result), .settle_active(settle_active),
  .cal_busy(cal_busy));
`default_nettype wire
